/* adcseq_defs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

// Register offsets on the plain register port.
`define ADCSEQ_OFF_CTRL0 4'h0
`define ADCSEQ_OFF_CTRL1 4'h1
`define ADCSEQ_OFF_CTRL2 4'h2
`define ADCSEQ_OFF_RES_HI 4'h3
`define ADCSEQ_OFF_RES_LO 4'h4
`define ADCSEQ_OFF_STAT 4'h5
`define ADCSEQ_OFF_MASK 4'h6

// Field positions of converter_control_zero.
`define ADCSEQ_C0_POWER 0
`define ADCSEQ_C0_GO 1
`define ADCSEQ_C0_CHAN_LSB 2
// Field positions of converter_control_one.
`define ADCSEQ_C1_PCFG_LSB 0
`define ADCSEQ_C1_REF_LSB 4
// Field positions of converter_control_two.
`define ADCSEQ_C2_ADCS_LSB 0
`define ADCSEQ_C2_ACQT_LSB 3
`define ADCSEQ_C2_JUST 7
// Position of conversion_done_flag in the status and mask registers.
`define ADCSEQ_ST_DONE 0

// Reset values.
`define ADCSEQ_RST_CHAN 4'h0
`define ADCSEQ_RST_REF 2'h0
`define ADCSEQ_RST_PCFG 4'h0
`define ADCSEQ_RST_ACQT 3'h0
`define ADCSEQ_RST_ADCS 3'h0
`define ADCSEQ_RST_RES 8'h00

// Compare-unit mode that requests a conversion on a special event.
`define ADCSEQ_TRIG_MODE 4'hb

// Timing: the clock, instruction cycle and derived cycle counts.
`define ADCSEQ_MCLK_NS 100
`define ADCSEQ_TCY_NS 400
`define ADCSEQ_WAIT_NS (2 * `ADCSEQ_TCY_NS)
`define ADCSEQ_WAIT_CYC ((`ADCSEQ_WAIT_NS + `ADCSEQ_MCLK_NS - 1) / `ADCSEQ_MCLK_NS)
`define ADCSEQ_HOLD_CYC ((`ADCSEQ_TCY_NS + `ADCSEQ_MCLK_NS - 1) / `ADCSEQ_MCLK_NS)
`define ADCSEQ_RC_TAD_NS 2500
`define ADCSEQ_RC_TAD_CYC (`ADCSEQ_RC_TAD_NS / `ADCSEQ_MCLK_NS)
`define ADCSEQ_CONV_TADS 13

`endif

/* adcseq_far_model.sv */
// Analog inputs and compare-unit trigger on the converter's far side.
`timescale 1ns/1ns
module adcseq_far_model (
  // Clock.
  input wire logic clk,
  // Converter side.
  input adcseq_pkg::adcseq_cfg_s cfg,
  input adcseq_pkg::adcseq_code_t dac_code,
  output logic cmp_above,
  // Bench controls: sixteen 12-bit input levels, mode and fire request.
  input wire logic [191:0] vin_all,
  input wire logic [3:0] mode_in,
  input wire logic fire,
  // Compare-unit side.
  output logic [3:0] cmp2_mode,
  output logic special_trig
);
  import adcseq_pkg::*;

  // Level of the channel that the converter selects.
  adcseq_code_t vin_sel;
  assign vin_sel = vin_all[cfg.channel * 12 +: 12];

  // The comparator answers for any trial code, powered or not.
  assign cmp_above = (vin_sel >= dac_code);

  // The mode field follows the bench setting.
  assign cmp2_mode = mode_in;

  // one-clock event
  // The special event lasts one clock, after the bench picked the mode.
  initial special_trig = 1'b0;
  always @(posedge clk) begin
    special_trig <= fire;
  end
endmodule : adcseq_far_model

/* adcseq_pkg.sv */
// Types shared by the conversion sequencer files.
package adcseq_pkg;

  // Sequencer states; the usual path steps one bit at a time.
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_ACQ = 3'h1,
    ST_CONV = 3'h3,
    ST_WAIT = 3'h2,
    ST_HOLD = 3'h4
  } adcseq_state_e;

  // One register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcseq_bus_s;

  // Static settings passed to the analog front end.
  typedef struct packed {
    logic [3:0] channel;
    logic [1:0] ref_sel;
    logic [3:0] pin_cfg;
    logic power_on;
  } adcseq_cfg_s;

  // A 12-bit conversion code.
  typedef logic [11:0] adcseq_code_t;

endpackage : adcseq_pkg

/* adcseq_tad_gen.sv */
// Bit-period tick generator for the conversion clock select field.
`timescale 1ns/1ns
`include "adcseq_defs.svh"
module adcseq_tad_gen #(
  parameter int RC_CYC = `ADCSEQ_RC_TAD_CYC
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Count while high; restart from zero while low.
  input wire logic run,
  input wire logic [2:0] sel,
  // One-cycle pulse at the end of each bit period.
  output logic tick
);

  // The counter is seven bits wide, so the RC period must fit in it.
  if (RC_CYC < 2 || RC_CYC > 127) begin : g_chk
    $error("RC_CYC must lie between 2 and 127");
  end

  // Maps the select code to oscillator periods per bit period.
  function automatic logic [6:0] tad_cycles(input logic [2:0] s);
    logic [6:0] r;
    r = 7'(RC_CYC);
    if (s[1:0] != 2'h3) begin
      case (s)
        3'h0: r = 7'h02;
        3'h4: r = 7'h04;
        3'h1: r = 7'h08;
        3'h5: r = 7'h10;
        3'h2: r = 7'h20;
        default: r = 7'h40;
      endcase
    end
    return r;
  endfunction : tad_cycles

  logic [6:0] cnt_q; // Oscillator periods counted in this bit period.
  logic [6:0] cnt_d; // Next count.
  wire [6:0] period = tad_cycles(sel); // Length of one bit period.
  wire last = (cnt_q == period - 7'h01); // Final period of the bit.

  assign tick = run && last;
  assign cnt_d = (!run || last) ? 7'h00 : cnt_q + 7'h01;

  // The counter freezes with the clock enable and clears on reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= 7'h00;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule : adcseq_tad_gen

/* adcseq_top.sv */
// Conversion sequencer of a 12-bit successive-approximation converter.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "adcseq_defs.svh"
module adcseq_top #(
  parameter int RC_TAD_CYC = `ADCSEQ_RC_TAD_CYC
) (
  // Clock, reset and clock enable.
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CE,
  // Register port.
  input adcseq_pkg::adcseq_bus_s BUS,
  output logic [7:0] RDATA,
  // Interrupt.
  output logic IRQ,
  // Analog front end.
  input wire logic CMP_ABOVE,
  output adcseq_pkg::adcseq_code_t DAC_CODE,
  output logic SAMPLE_EN,
  output logic DISCHARGE,
  output adcseq_pkg::adcseq_cfg_s CFG,
  // Compare unit trigger and timer clear.
  input wire logic [3:0] CMP2_MODE,
  input wire logic SPECIAL_TRIG,
  output logic TIMER_CLEAR
);
  import adcseq_pkg::*;

  // Register select for a given offset.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction : hit

  // Bit periods of the programmed acquisition time.
  function automatic logic [4:0] acq_tads(input logic [2:0] c);
    logic [4:0] r;
    r = 5'h00;
    case (c)
      3'h1: r = 5'h02;
      3'h2: r = 5'h04;
      3'h3: r = 5'h06;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0c;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : acq_tads

  // Control register state.
  logic power_q; // Converter powered.
  logic go_q; // Conversion requested or running.
  logic [3:0] chan_q; // Selected analog channel.
  logic [1:0] ref_q; // Reference source select.
  logic [3:0] pcfg_q; // Analog pin configuration.
  logic just_q; // One selects right-justified results.
  logic [2:0] acqt_q; // Acquisition time select.
  logic [2:0] adcs_q; // Conversion clock select.
  // Result, interrupt and sequencing state.
  logic [7:0] res_hi_q; // Result high byte.
  logic [7:0] res_lo_q; // Result low byte.
  logic stat_q; // Sticky conversion done flag.
  logic mask_q; // Interrupt enable for that flag.
  adcseq_state_e state_q; // Sequencer state.
  adcseq_state_e state_d; // Next state.
  logic [4:0] cnt_q; // Period or bit-period counter.
  logic [4:0] cnt_d; // Next counter value.
  logic [11:0] sar_q; // Trial code under test.
  logic [7:0] rdata_q; // Read data, one cycle after the strobe.
  logic tclr_q; // Timer clear pulse.
  logic tad_tick; // End of a bit period.

  // Register port decode.
  wire wr_c0 = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_CTRL0);
  wire wr_c1 = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_CTRL1);
  wire wr_c2 = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_CTRL2);
  wire wr_hi = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_RES_HI);
  wire wr_lo = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_RES_LO);
  wire wr_st = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_STAT);
  wire wr_mk = BUS.wr && hit(BUS.addr, `ADCSEQ_OFF_MASK);
  wire wgo = BUS.wdata[`ADCSEQ_C0_GO];

  // Register read views; reserved bits read as zero.
  wire [7:0] rd_c0 = {2'h0, chan_q, go_q, power_q};
  wire [7:0] rd_c1 = {2'h0, ref_q, pcfg_q};
  wire [7:0] rd_c2 = {just_q, 1'b0, acqt_q, adcs_q};
  wire [7:0] rd_st = {7'h00, stat_q};
  wire [7:0] rd_mk = {7'h00, mask_q};
  wire [7:0] rd_mux =
    hit(BUS.addr, `ADCSEQ_OFF_CTRL0) ? rd_c0 :
    hit(BUS.addr, `ADCSEQ_OFF_CTRL1) ? rd_c1 :
    hit(BUS.addr, `ADCSEQ_OFF_CTRL2) ? rd_c2 :
    hit(BUS.addr, `ADCSEQ_OFF_RES_HI) ? res_hi_q :
    hit(BUS.addr, `ADCSEQ_OFF_RES_LO) ? res_lo_q :
    hit(BUS.addr, `ADCSEQ_OFF_STAT) ? rd_st :
    hit(BUS.addr, `ADCSEQ_OFF_MASK) ? rd_mk : 8'h00;

  // Power control; a write that clears power also drops go.
  wire power_d = wr_c0 ? BUS.wdata[`ADCSEQ_C0_POWER] : power_q;
  wire trig_go = SPECIAL_TRIG && power_q && (CMP2_MODE == `ADCSEQ_TRIG_MODE);
  // Busy states, in which a cleared go bit means an abort.
  wire busy = (state_q == ST_ACQ) || (state_q == ST_HOLD) ||
    (state_q == ST_CONV);
  wire abort = busy && !go_q;
  wire done = (state_q == ST_CONV) && go_q && tad_tick &&
    (cnt_q == 5'(`ADCSEQ_CONV_TADS - 1));

  // Successive approximation step: bit under test and the next trial bit.
  wire [11:0] cur_bit = 12'h800 >> (cnt_q - 5'h01);
  wire [11:0] next_bit = cur_bit >> 1;
  wire [11:0] sar_step = (CMP_ABOVE ? sar_q : (sar_q & ~cur_bit)) | next_bit;
  // Final code in the selected justification.
  wire [7:0] jus_hi = just_q ? {4'h0, sar_step[11:8]} : sar_step[11:4];
  wire [7:0] jus_lo = just_q ? sar_step[7:0] : {sar_step[3:0], 4'h0};

  // Go bit: a trigger sets it, completion clears it, software writes it.
  logic go_d;
  always_comb begin
    go_d = go_q;
    if (!power_d) begin
      go_d = 1'b0;
    end else if (trig_go) begin
      go_d = 1'b1;
    end else if (done) begin
      go_d = 1'b0;
    end else if (wr_c0) begin
      go_d = wgo && power_q;
    end
  end

  // Bit-period generator, running only while acquiring or converting.
  adcseq_tad_gen #(
    .RC_CYC(RC_TAD_CYC)
  ) u_tad (
    .clk(MCLK),
    .rst_b(RST_B),
    .ce(CE),
    .run((state_q == ST_ACQ) || (state_q == ST_CONV)),
    .sel(adcs_q),
    .tick(tad_tick)
  );

  // Sequencer next state and counter.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (!power_q) begin
      // Unpowered: park in discharge so power-up starts clean.
      state_d = ST_WAIT;
      cnt_d = 5'(`ADCSEQ_WAIT_CYC - 1);
    end else begin
      unique case (state_q)
        ST_SAMPLE: begin
          if (go_q && acqt_q == 3'h0) begin
            state_d = ST_HOLD;
            cnt_d = 5'(`ADCSEQ_HOLD_CYC - 1);
          end else if (go_q) begin
            state_d = ST_ACQ;
            cnt_d = acq_tads(acqt_q) - 5'h01;
          end
        end
        ST_HOLD: begin
          // Sampling has stopped; count out the next instruction.
          if (abort) begin
            state_d = ST_WAIT;
            cnt_d = 5'(`ADCSEQ_WAIT_CYC - 1);
          end else if (cnt_q == 5'h00) begin
            state_d = ST_CONV;
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
        ST_ACQ: begin
          // Keep sampling for the programmed bit periods.
          if (abort) begin
            state_d = ST_WAIT;
            cnt_d = 5'(`ADCSEQ_WAIT_CYC - 1);
          end else if (tad_tick && cnt_q == 5'h00) begin
            state_d = ST_CONV;
          end else if (tad_tick) begin
            cnt_d = cnt_q - 5'h01;
          end
        end
        ST_CONV: begin
          // Counts bit periods upward; zero is the setup period.
          if (abort || done) begin
            state_d = ST_WAIT;
            cnt_d = 5'(`ADCSEQ_WAIT_CYC - 1);
          end else if (tad_tick) begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        ST_WAIT: begin
          if (cnt_q == 5'h00) begin
            state_d = ST_SAMPLE;
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
        default: begin
          state_d = ST_WAIT;
          cnt_d = 5'(`ADCSEQ_WAIT_CYC - 1);
        end
      endcase
    end
  end

  // Control registers.
  // reset powers off
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      power_q <= 1'b0;
      go_q <= 1'b0;
      chan_q <= `ADCSEQ_RST_CHAN;
      ref_q <= `ADCSEQ_RST_REF;
      pcfg_q <= `ADCSEQ_RST_PCFG;
      just_q <= 1'b0;
      acqt_q <= `ADCSEQ_RST_ACQT;
      adcs_q <= `ADCSEQ_RST_ADCS;
    end else if (CE) begin
      power_q <= power_d;
      go_q <= go_d;
      if (wr_c0) chan_q <= BUS.wdata[`ADCSEQ_C0_CHAN_LSB +: 4];
      if (wr_c1) ref_q <= BUS.wdata[`ADCSEQ_C1_REF_LSB +: 2];
      if (wr_c1) pcfg_q <= BUS.wdata[`ADCSEQ_C1_PCFG_LSB +: 4];
      if (wr_c2) just_q <= BUS.wdata[`ADCSEQ_C2_JUST];
      if (wr_c2) acqt_q <= BUS.wdata[`ADCSEQ_C2_ACQT_LSB +: 3];
      if (wr_c2) adcs_q <= BUS.wdata[`ADCSEQ_C2_ADCS_LSB +: 3];
    end
  end

  // Result pair: completion loads it, an abort never does.
  // result kept on abort
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      res_hi_q <= `ADCSEQ_RST_RES;
      res_lo_q <= `ADCSEQ_RST_RES;
    end else if (CE) begin
      if (done) res_hi_q <= jus_hi;
      else if (wr_hi) res_hi_q <= BUS.wdata;
      if (done) res_lo_q <= jus_lo;
      else if (wr_lo) res_lo_q <= BUS.wdata;
    end
  end

  // Done flag is write-one-to-clear; a completion in the same cycle wins.
  // done flag set
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      stat_q <= 1'b0;
      mask_q <= 1'b0;
    end else if (CE) begin
      stat_q <= done || (stat_q && !(wr_st && BUS.wdata[`ADCSEQ_ST_DONE]));
      if (wr_mk) mask_q <= BUS.wdata[`ADCSEQ_ST_DONE];
    end
  end

  // Sequencer state, trial code, read data and timer clear.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_q <= ST_WAIT;
      cnt_q <= 5'(`ADCSEQ_WAIT_CYC - 1);
      sar_q <= 12'h000;
      rdata_q <= 8'h00;
      tclr_q <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == ST_CONV && tad_tick && go_q) begin
        sar_q <= (cnt_q == 5'h00) ? 12'h800 : sar_step;
      end
      rdata_q <= BUS.rd ? rd_mux : 8'h00;
      tclr_q <= SPECIAL_TRIG;
    end
  end

  // Output drive.
  assign RDATA = rdata_q;
  assign IRQ = stat_q && mask_q;
  assign DAC_CODE = sar_q;
  assign SAMPLE_EN = power_q &&
    (state_q == ST_SAMPLE || state_q == ST_ACQ);
  assign DISCHARGE = power_q && (state_q == ST_WAIT);
  assign CFG = '{channel: chan_q, ref_sel: ref_q, pin_cfg: pcfg_q,
    power_on: power_q};
  assign TIMER_CLEAR = tclr_q;

  // Completion clears the go bit and raises the flag.
  a_done_clears_go: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE) done && !trig_go |=> !go_q && stat_q)
    else $error("completion did not clear go or set flag");

  // An abort leaves both result bytes as they were.
  a_abort_keeps_res: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE)
    abort && !wr_hi && !wr_lo |=> $stable(res_hi_q) && $stable(res_lo_q))
    else $error("abort altered the result registers");

  // A cleared go bit leaves the busy states in one cycle.
  a_abort_to_wait: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE) abort |=> state_q == ST_WAIT)
    else $error("abort did not end the conversion");

  // The wait after a conversion lasts eight cycles, then sampling.
  a_wait_length: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE)
    power_q && state_q == ST_CONV ##1 state_q == ST_WAIT |->
    (power_q && state_q == ST_WAIT)[*8] ##1 state_q == ST_SAMPLE)
    else $error("post-conversion wait has the wrong length");

  // Sampling only ever begins straight after discharge.
  a_disch_first: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE) $rose(SAMPLE_EN) |-> $past(DISCHARGE))
    else $error("sampling began without a discharge");

  // Every trigger clears the timer one cycle later.
  a_trig_timer: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE) SPECIAL_TRIG |=> TIMER_CLEAR)
    else $error("trigger did not clear the timer");

  // A trigger in compare mode 1011 sets go while powered.
  a_trig_sets_go: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE)
    SPECIAL_TRIG && power_q && CMP2_MODE == 4'hb && !wr_c0 |=> go_q)
    else $error("trigger did not set go");

  // While unpowered a trigger never sets go.
  a_trig_ignored: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE)
    SPECIAL_TRIG && !power_q |=> !go_q)
    else $error("trigger set go while powered off");

  // Manual mode holds one instruction, then converts.
  a_manual_hold: assert property (@(posedge MCLK)
    disable iff (!RST_B || !CE)
    state_q == ST_SAMPLE && power_q && go_q && acqt_q == 3'h0 && !wr_c0 |=>
    state_q == ST_HOLD ##1 (state_q == ST_HOLD && go_q)[*3] ##1
    state_q == ST_CONV)
    else $error("manual start did not wait one instruction");

endmodule : adcseq_top

/* tb_adcseq_top.sv */
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ns
`include "adcseq_defs.svh"
module tb_adcseq_top;
  import adcseq_pkg::*;
  // Shortened RC bit period keeps the run brief.
  localparam int RC_CYC = 4;
  // Acquisition length in bit periods for each code.
  int acq_tad[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  // Design ports.
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic CE = 1'b1;
  adcseq_bus_s BUS = '0;
  logic [7:0] RDATA;
  logic IRQ, CMP_ABOVE, SAMPLE_EN, DISCHARGE, SPECIAL_TRIG, TIMER_CLEAR;
  adcseq_code_t DAC_CODE;
  adcseq_cfg_s CFG;
  logic [3:0] CMP2_MODE;
  // Far model controls.
  logic [191:0] vin_all = '0;
  logic [3:0] mode_in = 4'h0;
  logic fire = 1'b0;
  // Counters and scratch.
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] rv;

  // A 100 ns clock.
  always #50 MCLK = ~MCLK;

  adcseq_top #(.RC_TAD_CYC(RC_CYC)) adcseq_top_i (
    .MCLK(MCLK), .RST_B(RST_B), .CE(CE), .BUS(BUS), .RDATA(RDATA),
    .IRQ(IRQ), .CMP_ABOVE(CMP_ABOVE), .DAC_CODE(DAC_CODE),
    .SAMPLE_EN(SAMPLE_EN), .DISCHARGE(DISCHARGE), .CFG(CFG),
    .CMP2_MODE(CMP2_MODE), .SPECIAL_TRIG(SPECIAL_TRIG),
    .TIMER_CLEAR(TIMER_CLEAR));

  adcseq_far_model adcseq_far_model_i (
    .clk(MCLK), .cfg(CFG), .dac_code(DAC_CODE), .cmp_above(CMP_ABOVE),
    .vin_all(vin_all), .mode_in(mode_in), .fire(fire),
    .cmp2_mode(CMP2_MODE), .special_trig(SPECIAL_TRIG));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Compares one value and reports a difference at once.
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp

  // Marks the end of one test.
  task automatic end_test(input string what);
    $display("test %s done", what);
  endtask : end_test

  // One strobe cycle; read data is captured in the cycle after it.
  task automatic bus_op(input logic [3:0] a, input logic [7:0] d,
                        input logic w, output logic [7:0] q);
    @(posedge MCLK);
    BUS <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge MCLK);
    BUS <= '0;
    #1 q = RDATA;
  endtask : bus_op

  // Register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_op(a, d, 1'b1, rv);
  endtask : wr

  // Register read against an expected value.
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e,
                        input string what);
    bus_op(a, 8'h00, 1'b0, rv);
    cmp(what, e, rv);
  endtask : chk_rd

  // Counts cycles until the post-conversion discharge starts.
  task automatic wait_dis(output int n);
    n = 0;
    while (DISCHARGE !== 1'b1 && n < 3000) begin
      @(posedge MCLK);
      #1 n++;
    end
  endtask : wait_dis

  // Discharge lasts two instruction cycles, then sampling resumes.
  task automatic chk_wait();
    int n;
    n = 0;
    while (DISCHARGE === 1'b1 && n < 20) begin
      @(posedge MCLK);
      #1 n++;
    end
    cmp("discharge_cycles", `ADCSEQ_WAIT_CYC, n);
    cmp("sample_after_discharge", 1, SAMPLE_EN);
  endtask : chk_wait

  // Bit period in clocks for a clock select code.
  function automatic int tad_of(input logic [2:0] c);
    case (c)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return RC_CYC;
    endcase
  endfunction : tad_of

  // Result pair for a code, right justified when jst is set.
  function automatic logic [15:0] res_of(input adcseq_code_t v,
                                         input logic jst);
    return jst ? {4'h0, v} : {v, 4'h0};
  endfunction : res_of

  // Waits for completion and checks timing, result, go and flag.
  task automatic fin(input logic [3:0] ch, input logic jst, input int k);
    int n;
    logic [15:0] r;
    r = res_of(vin_all[ch * 12 +: 12], jst);
    wait_dis(n);
    cmp("conv_cycles", 1, (n >= k - 1) && (n <= k + 1));
    chk_wait();
    cmp("cfg_channel", ch, CFG.channel);
    chk_rd(`ADCSEQ_OFF_RES_HI, r[15:8], "result_high");
    chk_rd(`ADCSEQ_OFF_RES_LO, r[7:0], "result_low");
    chk_rd(`ADCSEQ_OFF_CTRL0, {2'h0, ch, 2'h1}, "go_cleared");
    chk_rd(`ADCSEQ_OFF_STAT, 8'h01, "done_flag");
  endtask : fin

  // Software-started conversion on channel ch.
  task automatic conv(input logic [2:0] acq, input logic [2:0] ck,
                      input logic [3:0] ch, input logic jst);
    int k;
    k = (acq == 3'h0) ? 5 : acq_tad[acq] * tad_of(ck);
    wr(`ADCSEQ_OFF_CTRL2, {jst, 1'b0, acq, ck});
    wr(`ADCSEQ_OFF_CTRL0, {2'h0, ch, 2'h1});
    wr(`ADCSEQ_OFF_CTRL0, {2'h0, ch, 2'h3});
    fin(ch, jst, k + 13 * tad_of(ck));
  endtask : conv

  // One special event; the timer clear must follow it.
  task automatic trig(input logic [3:0] mode);
    @(posedge MCLK);
    mode_in <= mode;
    fire <= 1'b1;
    @(posedge MCLK);
    fire <= 1'b0;
    @(posedge MCLK);
    #1 cmp("timer_clear", 1, TIMER_CLEAR);
  endtask : trig

  // Cuts a hung run short.
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Main sequence.
  initial begin : main
    logic [3:0] ch;
    logic [2:0] acq;
    logic [7:0] c1v;
    int n;
    void'($urandom(32'h2ee1));
    // Full scale on channel 0, zero on channel 15, random elsewhere.
    for (int i = 0; i < 16; i++) begin
      vin_all[i * 12 +: 12] <= (i == 0) ? 12'hfff :
                               (i == 15) ? 12'h000 : 12'($urandom);
    end
    repeat (16) @(posedge MCLK);
    RST_B <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      chk_rd(a[3:0], 8'h00, "reset_value");
    end
    end_test("reset");
    // Go in the power-on write is dropped; then a settling wait.
    wr(`ADCSEQ_OFF_CTRL0, 8'h03);
    chk_rd(`ADCSEQ_OFF_CTRL0, 8'h01, "go_with_power");
    repeat (20) @(posedge MCLK);
    end_test("power");
    // RC codes run awake here; accuracy is not modelled.
    for (int c = 0; c < 8; c++) begin
      ch = (c < 2) ? 4'(c * 15) : 4'($urandom);
      acq = (c == 2) ? 3'h2 : (c == 0) ? 3'h0 : 3'($urandom);
      conv(acq, c[2:0], ch, c[0] ^ 1'($urandom));
      cmp("irq_masked", 0, IRQ);
      wr(`ADCSEQ_OFF_STAT, 8'h01);
    end
    end_test("clock_codes");
    conv(3'h7, 3'h0, 4'h5, 1'b1);
    // A write while the clock enable is low must be lost.
    @(posedge MCLK);
    CE <= 1'b0;
    wr(`ADCSEQ_OFF_MASK, 8'h01);
    @(posedge MCLK);
    CE <= 1'b1;
    chk_rd(`ADCSEQ_OFF_MASK, 8'h00, "mask_frozen");
    cmp("irq_frozen", 0, IRQ);
    wr(`ADCSEQ_OFF_MASK, 8'h01);
    cmp("irq_on", 1, IRQ);
    wr(`ADCSEQ_OFF_STAT, 8'h01);
    cmp("irq_cleared", 0, IRQ);
    chk_rd(`ADCSEQ_OFF_STAT, 8'h00, "flag_cleared");
    end_test("interrupt");
    wr(`ADCSEQ_OFF_CTRL2, 8'h10);
    wr(`ADCSEQ_OFF_CTRL0, 8'h09);
    trig(4'hb);
    fin(4'h2, 1'b0, 4 * 2 + 13 * 2 + 1);
    wr(`ADCSEQ_OFF_STAT, 8'h01);
    trig(4'ha);
    repeat (10) @(posedge MCLK);
    chk_rd(`ADCSEQ_OFF_CTRL0, 8'h09, "go_other_mode");
    wr(`ADCSEQ_OFF_CTRL0, 8'h08);
    trig(4'hb);
    repeat (10) @(posedge MCLK);
    chk_rd(`ADCSEQ_OFF_CTRL0, 8'h08, "go_powered_off");
    cmp("sample_off", 0, SAMPLE_EN);
    end_test("trigger");
    wr(`ADCSEQ_OFF_CTRL0, 8'h0d);
    repeat (20) @(posedge MCLK);
    wr(`ADCSEQ_OFF_RES_HI, 8'h5a);
    wr(`ADCSEQ_OFF_RES_LO, 8'ha5);
    wr(`ADCSEQ_OFF_CTRL2, 8'h06);
    wr(`ADCSEQ_OFF_CTRL0, 8'h0f);
    repeat (200) @(posedge MCLK);
    wr(`ADCSEQ_OFF_CTRL0, 8'h0d);
    wait_dis(n);
    cmp("abort_delay", 1, n <= 2);
    chk_wait();
    chk_rd(`ADCSEQ_OFF_RES_HI, 8'h5a, "kept_high");
    chk_rd(`ADCSEQ_OFF_RES_LO, 8'ha5, "kept_low");
    chk_rd(`ADCSEQ_OFF_STAT, 8'h00, "no_flag");
    end_test("abort");
    // Reference and pin settings reach the analog side as written.
    c1v = 8'($urandom) & 8'h3f;
    wr(`ADCSEQ_OFF_CTRL1, c1v);
    chk_rd(`ADCSEQ_OFF_CTRL1, c1v, "ctrl1_readback");
    cmp("cfg_pin", c1v[3:0], CFG.pin_cfg);
    cmp("cfg_ref", c1v[5:4], CFG.ref_sel);
    wr(`ADCSEQ_OFF_CTRL2, 8'h1f);
    wr(`ADCSEQ_OFF_CTRL0, 8'h0f);
    repeat (30) @(posedge MCLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_B <= 1'b1;
    chk_rd(`ADCSEQ_OFF_CTRL0, 8'h00, "ctrl0_after_reset");
    chk_rd(`ADCSEQ_OFF_CTRL2, 8'h00, "ctrl2_after_reset");
    chk_rd(`ADCSEQ_OFF_CTRL1, 8'h00, "ctrl1_after_reset");
    cmp("sample_after_reset", 0, SAMPLE_EN);
    end_test("mid_reset");
    stop_test();
  end
endmodule : tb_adcseq_top
